// [pkg/gci_pkg.sv]
// constants for the gci c/i and monitor channel controller
package gci_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CIX = 8'h04;
    localparam logic [7:0] OFF_CIR = 8'h08;
    localparam logic [7:0] OFF_MOX = 8'h0C;
    localparam logic [7:0] OFF_MOR = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_ISR = 8'h18;
    localparam logic [7:0] OFF_ICLR = 8'h1C;
    localparam logic [7:0] OFF_IEN = 8'h20;
    // control register bits
    localparam int CB_MRC = 0;
    localparam int CB_MXC = 1;
    localparam int CB_MIE = 2;
    localparam int CB_MST = 3;
    // status register bit
    localparam int SB_MAC = 0;
    // interrupt bits
    localparam int IB_CIC = 0;
    localparam int IB_MDR = 1;
    localparam int IB_MER = 2;
    localparam int IB_MDA = 3;
    localparam int IB_MAB = 4;
    localparam int INT_W = 5;
    // link timing
    localparam int FRAME_HZ = 8000;
    localparam int DCLK_HZ = 1536000;
    localparam int EDGES_PER_FRAME = DCLK_HZ / FRAME_HZ;
    localparam logic [7:0] EDGE_LAST = 8'(EDGES_PER_FRAME - 1);
    // octet slots of monitor and c/i per timeslot group
    localparam logic [3:0] OCT_MON0 = 4'h2;
    localparam logic [3:0] OCT_CI0 = 4'h3;
    localparam logic [3:0] OCT_MON1 = 4'h6;
    localparam logic [3:0] OCT_CI1 = 4'h7;
    // values after reset
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] CODE_RST = 4'hF;
    localparam logic [7:0] BYTE_RST = 8'hFF;
    localparam logic [4:0] IEN_RST = 5'h00;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gci_pkg

// [rtl/gci_ci_monitor_channel.sv]
// gci c/i and monitor channel controller, channel 0 or 1 chosen by MST, with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module gci_ci_monitor_channel (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic data_clock,
    input wire logic frame_sync,
    input wire logic data_downstream,
    output logic data_upstream,
    output logic irq
);
    // byte sent in a given octet of the frame
    function automatic logic [7:0] f_tx(input logic [3:0] oct, input logic mst,
        input logic [7:0] monitor_tx_data, input logic [3:0] code_transmit_reg, input logic mr, input logic mx);
        logic [3:0] om;
        logic [3:0] oc;
        om = mst ? gci_pkg::OCT_MON1 : gci_pkg::OCT_MON0;
        oc = mst ? gci_pkg::OCT_CI1 : gci_pkg::OCT_CI0;
        if (oct == om) begin
            f_tx = monitor_tx_data;
        end else if (oct == oc) begin
            f_tx = {2'h3, code_transmit_reg, mr, mx};
        end else begin
            f_tx = gci_pkg::BYTE_RST;
        end
    endfunction : f_tx

    // word aligned register hit
    function automatic logic f_hit(input logic [7:0] a, input logic [7:0] off);
        f_hit = ({a[7:2], 2'h0} == off);
    endfunction : f_hit

    // reset release through two flops
    logic [1:0] rst_sq;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sq <= 2'h0;
        end else begin
            rst_sq <= {rst_sq[0], 1'h1};
        end
    end
    assign rst_n = rst_sq[1];

    // link pins pass two flops; edge logic only sees the second
    logic [1:0] dc_sq;
    logic [1:0] fs_sq;
    logic [1:0] dd_sq;
    logic dc_prev_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dc_sq <= 2'h0;
            fs_sq <= 2'h0;
            dd_sq <= 2'h3;
            dc_prev_q <= 1'h0;
        end else begin
            dc_sq <= {dc_sq[0], data_clock};
            fs_sq <= {fs_sq[0], frame_sync};
            dd_sq <= {dd_sq[0], data_downstream};
            dc_prev_q <= dc_sq[1];
        end
    end

    logic dc_rise;
    logic fs_prev_q;
    logic [7:0] edge_q;
    logic [7:0] edge_nx;
    logic [3:0] oct_nx;
    logic [2:0] bit_nx;
    assign dc_rise = dc_sq[1] & ~dc_prev_q;
    // two clock edges per bit, 192 per frame, restarted by frame sync
    always_comb begin
        if (fs_sq[1] && !fs_prev_q) begin
            edge_nx = 8'h00;
        end else if (edge_q != gci_pkg::EDGE_LAST) begin
            edge_nx = edge_q + 8'h01;
        end else begin
            edge_nx = edge_q;
        end
    end
    assign oct_nx = edge_nx[7:4];
    assign bit_nx = edge_nx[3:1];

    // control and data registers
    logic [3:0] ctrl_q;
    logic [3:0] cix_q;
    logic [7:0] mox_q;
    logic rx_handshake_ctl;
    logic tx_handshake_ctl;
    logic mie;
    logic mst;
    assign rx_handshake_ctl = ctrl_q[gci_pkg::CB_MRC];
    assign tx_handshake_ctl = ctrl_q[gci_pkg::CB_MXC];
    assign mie = ctrl_q[gci_pkg::CB_MIE];
    assign mst = ctrl_q[gci_pkg::CB_MST];

    logic mr_q;
    logic mx_q;
    logic [7:0] rx_sh_q;
    logic [7:0] mon_q;
    logic [7:0] ci_q;
    logic frm_q;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    assign rx_byte = {rx_sh_q[6:0], dd_sq[1]};
    assign tx_byte = f_tx(oct_nx, mst, mox_q, cix_q, mr_q, mx_q);

    // bit engine: drive on the first clock of a bit, sample on the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_prev_q <= 1'h0;
            edge_q <= gci_pkg::EDGE_LAST;
            rx_sh_q <= gci_pkg::BYTE_RST;
            mon_q <= gci_pkg::BYTE_RST;
            ci_q <= gci_pkg::BYTE_RST;
            frm_q <= 1'h0;
            data_upstream <= 1'h1;
        end else begin
            frm_q <= 1'h0;
            if (dc_rise) begin
                fs_prev_q <= fs_sq[1];
                edge_q <= edge_nx;
                if (!edge_nx[0]) begin
                    data_upstream <= tx_byte[~bit_nx];
                end else begin
                    rx_sh_q <= rx_byte;
                    if (bit_nx == 3'h7 && oct_nx == (mst ? gci_pkg::OCT_MON1 : gci_pkg::OCT_MON0)) begin
                        mon_q <= rx_byte;
                    end
                    if (bit_nx == 3'h7 && oct_nx == (mst ? gci_pkg::OCT_CI1 : gci_pkg::OCT_CI0)) begin
                        ci_q <= rx_byte;
                        frm_q <= 1'h1;
                    end
                end
            end
        end
    end

    // fields of the received c/i octet
    logic [3:0] ci_in;
    logic mr_in;
    logic mx_in;
    assign ci_in = ci_q[5:2];
    assign mr_in = ci_q[1];
    assign mx_in = ci_q[0];

    // double last look on the incoming code
    logic [3:0] cand_q;
    logic [3:0] cir_q;
    logic cic_ev;
    assign cic_ev = frm_q && ci_in == cand_q && ci_in != cir_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_q <= gci_pkg::CODE_RST;
            cir_q <= gci_pkg::CODE_RST;
        end else if (frm_q) begin
            cand_q <= ci_in;
            if (cic_ev) begin
                cir_q <= ci_in;
            end
        end
    end

    // monitor receiver
    logic mx_prev_q;
    logic mr_prev_q;
    logic rx_act_q;
    logic rx_pend_q;
    logic rx_read_q;
    logic mr_pul_q;
    logic [7:0] mor_q;
    logic rd_mor;
    logic rx_ev;
    logic ack_ev;
    logic mer_ev;
    // later bytes only stored once software has enabled the handshake
    assign rx_ev = frm_q && !mx_in && mx_prev_q && (!rx_act_q || rx_handshake_ctl);
    assign ack_ev = frm_q && rx_handshake_ctl && rx_pend_q && rx_read_q;
    assign mer_ev = frm_q && rx_act_q && mx_in && mx_prev_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mx_prev_q <= 1'h1;
            mr_prev_q <= 1'h1;
            rx_act_q <= 1'h0;
            rx_pend_q <= 1'h0;
            mor_q <= gci_pkg::BYTE_RST;
        end else if (frm_q) begin
            mx_prev_q <= mx_in;
            mr_prev_q <= mr_in;
            if (rx_ev) begin
                mor_q <= mon_q;
                rx_pend_q <= 1'h1;
                rx_act_q <= 1'h1;
            end else if (mer_ev) begin
                rx_act_q <= 1'h0;
                rx_pend_q <= 1'h0;
            end else if (ack_ev) begin
                rx_pend_q <= 1'h0;
            end
        end
    end

    // remembers that software fetched the stored byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_read_q <= 1'h0;
        end else if (rx_ev) begin
            rx_read_q <= 1'h0;
        end else if (rd_mor) begin
            rx_read_q <= 1'h1;
        end
    end

    // MR: first ack drops it, later acks pulse it high for one frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mr_q <= 1'h1;
            mr_pul_q <= 1'h0;
        end else if (frm_q) begin
            if (!rx_handshake_ctl) begin
                mr_q <= 1'h1;
                mr_pul_q <= 1'h0;
            end else if (ack_ev) begin
                mr_q <= ~mr_q;
                mr_pul_q <= ~mr_q;
            end else if (mr_pul_q) begin
                mr_q <= 1'h0;
                mr_pul_q <= 1'h0;
            end
        end
    end

    // monitor transmitter
    logic tx_new_q;
    logic tx_wait_q;
    logic tx_acked_q;
    logic mx_pul_q;
    logic mac_q;
    logic mda_ev;
    logic mab_ev;
    logic go_new;
    logic sent;
    logic wr_mox;
    logic wr_ctrl;
    logic [31:0] wd_q;
    assign mda_ev = frm_q && tx_wait_q && !mr_in && mr_prev_q;
    assign mab_ev = frm_q && tx_handshake_ctl && tx_acked_q && mr_in && mr_prev_q;
    assign go_new = frm_q && tx_handshake_ctl && !mx_pul_q && !mda_ev && !mab_ev && tx_new_q && !tx_wait_q;
    assign sent = (frm_q && tx_handshake_ctl && mx_pul_q) || (go_new && mx_q);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mx_q <= 1'h1;
            mx_pul_q <= 1'h0;
            tx_wait_q <= 1'h0;
            tx_acked_q <= 1'h0;
        end else if (frm_q) begin
            if (!tx_handshake_ctl) begin
                mx_q <= 1'h1;
                mx_pul_q <= 1'h0;
                tx_wait_q <= 1'h0;
                tx_acked_q <= 1'h0;
            end else if (mx_pul_q) begin
                mx_q <= 1'h0;
                mx_pul_q <= 1'h0;
                tx_wait_q <= 1'h1;
            end else if (mda_ev) begin
                tx_wait_q <= 1'h0;
                tx_acked_q <= 1'h1;
            end else if (mab_ev) begin
                tx_wait_q <= 1'h0;
                tx_acked_q <= 1'h0;
            end else if (go_new) begin
                // first byte goes active at once, later bytes idle one frame first
                mx_q <= ~mx_q;
                mx_pul_q <= ~mx_q;
                tx_wait_q <= mx_q;
            end
        end
    end

    // byte pending flag; a fresh write wins over the send
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_new_q <= 1'h0;
        end else if (wr_mox) begin
            tx_new_q <= 1'h1;
        end else if (sent) begin
            tx_new_q <= 1'h0;
        end
    end

    // tx active: set by enabling MX, cleared when MR idles after MX off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_q <= 1'h0;
        end else if (wr_ctrl && wd_q[gci_pkg::CB_MXC]) begin
            mac_q <= 1'h1;
        end else if (mab_ev || (frm_q && !tx_handshake_ctl && mr_in && mr_prev_q)) begin
            mac_q <= 1'h0;
        end
    end

    // axi4-lite write path
    logic [7:0] awa_q;
    logic do_wr;
    logic [4:0] isr_q;
    logic [4:0] ien_q;
    logic [4:0] ev;
    logic [4:0] clr;
    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ctrl = do_wr && s_axi_wstrb[0] && f_hit(awa_q, gci_pkg::OFF_CTRL);
    assign wr_mox = do_wr && s_axi_wstrb[0] && f_hit(awa_q, gci_pkg::OFF_MOX);
    assign clr = (do_wr && s_axi_wstrb[0] && f_hit(awa_q, gci_pkg::OFF_ICLR)) ? wd_q[4:0] : 5'h00;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'h1;
            s_axi_wready <= 1'h1;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= gci_pkg::RESP_OKAY;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awa_q <= s_axi_awaddr;
                s_axi_awready <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q <= s_axi_wdata;
                s_axi_wready <= 1'h0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= (awa_q <= gci_pkg::OFF_IEN) ? gci_pkg::RESP_OKAY
                    : gci_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready <= 1'h1;
            end
        end
    end

    // writable registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= gci_pkg::CTRL_RST;
            cix_q <= gci_pkg::CODE_RST;
            mox_q <= gci_pkg::BYTE_RST;
            ien_q <= gci_pkg::IEN_RST;
        end else if (do_wr && s_axi_wstrb[0]) begin
            if (f_hit(awa_q, gci_pkg::OFF_CTRL)) begin
                ctrl_q <= wd_q[3:0];
            end else if (f_hit(awa_q, gci_pkg::OFF_CIX)) begin
                cix_q <= wd_q[3:0];
            end else if (f_hit(awa_q, gci_pkg::OFF_MOX)) begin
                mox_q <= wd_q[7:0];
            end else if (f_hit(awa_q, gci_pkg::OFF_IEN)) begin
                ien_q <= wd_q[4:0];
            end
        end
    end

    // sticky status, set beats clear; acked/end/abort need monitor enable
    assign ev = {mab_ev && mie, mda_ev && mie, mer_ev && mie, rx_ev, cic_ev};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_q <= 5'h00;
            irq <= 1'h0;
        end else begin
            isr_q <= (isr_q & ~clr) | ev;
            irq <= |(isr_q & ien_q);
        end
    end

    // axi4-lite read path; reading the monitor data arms the ack
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'h1;
        rd_val = 32'h0;
        if (f_hit(s_axi_araddr, gci_pkg::OFF_CTRL)) begin
            rd_val[3:0] = ctrl_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_CIX)) begin
            rd_val[3:0] = cix_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_CIR)) begin
            rd_val[3:0] = cir_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_MOX)) begin
            rd_val[7:0] = mox_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_MOR)) begin
            rd_val[7:0] = mor_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_STAT)) begin
            rd_val[gci_pkg::SB_MAC] = mac_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_ISR)) begin
            rd_val[4:0] = isr_q;
        end else if (f_hit(s_axi_araddr, gci_pkg::OFF_IEN)) begin
            rd_val[4:0] = ien_q;
        end else if (!f_hit(s_axi_araddr, gci_pkg::OFF_ICLR)) begin
            rd_ok = 1'h0;
        end
    end
    assign rd_mor = s_axi_arvalid && s_axi_arready && f_hit(s_axi_araddr, gci_pkg::OFF_MOR);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= gci_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? gci_pkg::RESP_OKAY : gci_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
            s_axi_arready <= 1'h1;
        end
    end

    // checks, frame steps are one-cycle pulses on frm_q
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_mr_fall;
        frm_q && !mr_in && mr_prev_q;
    endsequence
    sequence s_mr_idle2;
        frm_q && mr_in && mr_prev_q;
    endsequence
    sequence s_mx_idle2;
        frm_q && mx_in && mx_prev_q;
    endsequence
    a_mr_forced_idle: assert property (frm_q && !rx_handshake_ctl |=> mr_q && !mr_pul_q)
        else $error("MR not idle with handshake off");
    a_mx_forced_idle: assert property (frm_q && !tx_handshake_ctl |=> mx_q && !tx_wait_q)
        else $error("MX not idle with handshake off");
    // watches the pin itself, so a broken channel 0 slot or bit order is caught
    a_ci_tx_field: assert property (dc_rise && !edge_nx[0] && !mst && oct_nx == gci_pkg::OCT_CI0
        && bit_nx >= 3'h2 && bit_nx <= 3'h5
        |=> data_upstream == $past(cix_q[2'(3'h5 - bit_nx)]))
        else $error("c/i octet does not carry the transmit code");
    a_ci_double: assert property (frm_q && ci_in == cand_q && ci_in != cir_q
        |=> cir_q == $past(ci_in) && isr_q[gci_pkg::IB_CIC])
        else $error("code change not accepted after two frames");
    a_ci_single: assert property (frm_q && ci_in != cand_q |=> $stable(cir_q))
        else $error("code accepted after one frame");
    a_mdr_store: assert property (rx_ev |=> mor_q == $past(mon_q)
        && isr_q[gci_pkg::IB_MDR])
        else $error("monitor byte not stored");
    a_mx_resend: assert property (frm_q && tx_handshake_ctl && tx_wait_q && mr_in && !mx_pul_q
        |=> !mx_q)
        else $error("MX dropped before acknowledge");
    a_mda_on_ack: assert property (s_mr_fall ##0 (tx_wait_q && mie)
        |=> isr_q[gci_pkg::IB_MDA] && !tx_wait_q)
        else $error("acknowledge not flagged");
    a_mx_one_frame: assert property (frm_q && tx_handshake_ctl && mx_pul_q |=> !mx_q && tx_wait_q)
        else $error("MX inactive longer than one frame");
    a_mer_on_idle: assert property (s_mx_idle2 ##0 (rx_act_q && mie)
        |=> isr_q[gci_pkg::IB_MER] && !rx_act_q)
        else $error("end of reception missed");
    a_mab_on_idle: assert property (s_mr_idle2 ##0 (tx_handshake_ctl && tx_acked_q && mie)
        |=> isr_q[gci_pkg::IB_MAB] && !mac_q)
        else $error("abort not flagged");
    a_mac_set: assert property (wr_ctrl && wd_q[gci_pkg::CB_MXC] |=> mac_q)
        else $error("tx active not set");
endmodule : gci_ci_monitor_channel
`default_nettype wire

// [verif/gci_link_model.sv]
// far-end layer-1 model: link clock, frame sync, c/i and monitor octets
`timescale 1ns/1ps
`default_nettype none
module gci_link_model (
    output logic data_clock,
    output logic frame_sync,
    output logic data_downstream,
    input wire logic data_upstream,
    input wire logic [7:0] mon_tx,
    input wire logic [7:0] ci_tx,
    output logic [7:0] mon_rx,
    output logic [7:0] ci_rx,
    output int frames
);
    logic [7:0] sh;
    logic [7:0] oct;
    // free-running link clock, 96 bits per frame; pulled-up bus, idle octets all ones
    initial begin
        data_clock = 1'b0;
        frame_sync = 1'b0;
        data_downstream = 1'b1;
        frames = 0;
        // start after reset so the first frame is aligned; 1 ns off the system clock grid
        #101;
        forever begin
            for (int b = 0; b < 96; b++) begin
                oct = (b / 8 == 2) ? mon_tx : (b / 8 == 3) ? ci_tx : 8'hFF;
                #32 data_clock = 1'b0;
                frame_sync = (b == 0);
                data_downstream = oct[7 - b % 8];
                #32 data_clock = 1'b1;
                #32 data_clock = 1'b0;
                #32 data_clock = 1'b1;
                // upstream changes on the first rise of a bit, so take it on the second
                sh = {sh[6:0], data_upstream};
                if (b == 23) mon_rx = sh;
                if (b == 31) ci_rx = sh;
            end
            frames++;
        end
    end
endmodule : gci_link_model
`default_nettype wire

// [verif/tb_gci_ci_monitor_channel.sv]
// self-checking bench for the c/i and monitor channel controller
`timescale 1ns/1ps
`default_nettype none
module tb_gci_ci_monitor_channel;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dclk, fsync, ddn, dup, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [7:0] mon_tx = 8'hFF, ci_tx = 8'hFF, mon_rx, ci_rx, b0, b1, rb;
    logic [3:0] code;
    int frames, err_count = 0, compares = 0;
    always #2 sys_clk = ~sys_clk;
    gci_ci_monitor_channel gci_ci_monitor_channel_inst (.sys_clk(sys_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_clock(dclk),
        .frame_sync(fsync), .data_downstream(ddn), .data_upstream(dup), .irq(irq));
    gci_link_model gci_link_model_inst (.data_clock(dclk), .frame_sync(fsync),
        .data_downstream(ddn), .data_upstream(dup), .mon_tx(mon_tx), .ci_tx(ci_tx),
        .mon_rx(mon_rx), .ci_rx(ci_rx), .frames(frames));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr
    // wait for n frames to end at the far side
    task automatic fw(input int n);
        int f;
        f = frames;
        wait (frames == f + n);
        @(posedge sys_clk);
    endtask : fw
    task automatic results;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    // about 21 frames of 3072 cycles each fit well inside this
    initial begin
        #300000;
        err_count++;
        results();
    end
    initial begin
        d = $urandom(19292);
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        axr(gci_pkg::OFF_CIR);
        chk(d, 32'hF);
        axr(8'h24);
        chk(32'(r), 32'(gci_pkg::RESP_SLVERR));
        axw(8'h24, 32'h0);
        chk(32'(r), 32'(gci_pkg::RESP_SLVERR));
        code = 4'($urandom % 15);
        axw(gci_pkg::OFF_CIX, 32'(code));
        axw(gci_pkg::OFF_IEN, 32'h1F);
        // a code seen in one frame only must be ignored
        ci_tx <= {2'b11, code, 2'b11};
        fw(1);
        ci_tx <= 8'hFF;
        fw(2);
        chk(32'(ci_rx), {24'h0, 2'b11, code, 2'b11});
        axr(gci_pkg::OFF_CIR);
        chk(d, 32'hF);
        ci_tx <= {2'b11, code, 2'b11};
        fw(2);
        axr(gci_pkg::OFF_CIR);
        chk(d, 32'(code));
        chk(32'(irq), 32'h1);
        axw(gci_pkg::OFF_IEN, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        axw(gci_pkg::OFF_ICLR, 32'h1F);
        axr(gci_pkg::OFF_ISR);
        chk(d, 32'h0);
        // monitor transmit: first byte repeated until acknowledged
        axr(gci_pkg::OFF_STAT);
        chk(d, 32'h0);
        b0 = 8'($urandom);
        axw(gci_pkg::OFF_MOX, 32'(b0));
        axw(gci_pkg::OFF_CTRL, 32'h6);
        axr(gci_pkg::OFF_STAT);
        chk(d, 32'h1);
        fw(2);
        chk(32'({mon_rx, ci_rx[0]}), 32'({b0, 1'b0}));
        fw(1);
        chk(32'({mon_rx, ci_rx[0]}), 32'({b0, 1'b0}));
        ci_tx <= {2'b11, code, 2'b01};
        fw(1);
        axr(gci_pkg::OFF_ISR);
        chk(32'(d[3]), 32'h1);
        b1 = 8'($urandom);
        axw(gci_pkg::OFF_MOX, 32'(b1));
        for (int i = 0; i < 3 && ci_rx[0] !== 1'b1; i++) fw(1);
        chk(32'(ci_rx[0]), 32'h1);
        fw(1);
        chk(32'({mon_rx, ci_rx[0]}), 32'({b1, 1'b0}));
        axw(gci_pkg::OFF_CTRL, 32'h4);
        fw(2);
        chk(32'(ci_rx[0]), 32'h1);
        ci_tx <= {2'b11, code, 2'b11};
        fw(2);
        axr(gci_pkg::OFF_STAT);
        chk(d, 32'h0);
        // monitor receive from the far side
        axw(gci_pkg::OFF_ICLR, 32'h1F);
        rb = 8'($urandom);
        mon_tx <= rb;
        ci_tx <= {2'b11, code, 2'b10};
        fw(1);
        axr(gci_pkg::OFF_MOR);
        chk(d, 32'(rb));
        axr(gci_pkg::OFF_ISR);
        chk(32'(d[1]), 32'h1);
        axw(gci_pkg::OFF_CTRL, 32'h5);
        fw(2);
        chk(32'(ci_rx[1]), 32'h0);
        ci_tx <= {2'b11, code, 2'b11};
        fw(2);
        axr(gci_pkg::OFF_ISR);
        chk(32'(d[2]), 32'h1);
        results();
    end
endmodule : tb_gci_ci_monitor_channel
`default_nettype wire
